/* File: fnwc_defines.svh */
// constants for the non-secure flash write control block
// assumes inclusion by bare name from every file that uses its macros
`ifndef FNWC_DEFINES_SVH
`define FNWC_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define FNWC_ADDR_ACCESS_MODE 12'h584
`define FNWC_ADDR_PROTECT_PERM 12'h588
`define FNWC_ADDR_OP_CTRL 12'h590
`define FNWC_ADDR_OP_STATUS 12'h594
// ----------------------------------------
// field values and layout
// ----------------------------------------
`define FNWC_MODE_READ 2'h0
`define FNWC_MODE_WRITE 2'h1
`define FNWC_MODE_ERASE 2'h2
`define FNWC_MODE_MSB 1
`define FNWC_KEY_VALID 28'hafbe5a7
`define FNWC_KEY_LSB 4
`define FNWC_KEY_MSB 31
`define FNWC_PERM_SET_BIT 0
`define FNWC_ACCESS_RESET 2'h0
`define FNWC_OPC_WRITE 0
`define FNWC_OPC_ERASE_PAGE 1
`define FNWC_OPC_ERASE_ALL 2
`define FNWC_OPC_ERASE_PART 3
`define FNWC_PART_MS_LSB 8
`define FNWC_PART_MS_MSB 15
`define FNWC_ZERO_WORD 32'h00000000
// ----------------------------------------
// timing
// ----------------------------------------
`define FNWC_CLK_KHZ 40000
`define FNWC_T_WRITE_US 43
`define FNWC_T_ERASE_PAGE_MS 87
`define FNWC_T_ERASE_ALL_MS 173
`define FNWC_T_PART_SETUP_US 1080
`define FNWC_CNT_W 24
`define FNWC_MIN_OP_CYC 3
`endif

/* File: fnwc_pkg.sv */
// types for the non-secure flash write control block
// assumes fnwc_defines.svh is compiled alongside
package fnwc_pkg;
    typedef enum logic [1:0] {
        FNWC_OP_IDLE,
        FNWC_OP_BUSY
    } fnwc_op_state_t;
endpackage

/* File: fnwc_timer.sv */
// one-shot down counter timing a flash operation
// assumes a load pulse and a cycle count from the same clock
`timescale 1ns/1ps
module fnwc_timer #(
    parameter int CNT_W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [CNT_W-1:0] cycles,
    output logic done
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic run_q;
    logic run_d;
    logic done_q;
    logic done_d;

    if (CNT_W < 2) begin : g_bad_width
        $error("fnwc_timer: CNT_W too small");
    end

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (load) begin
            cnt_d = cycles;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                run_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
endmodule

/* File: fnwc_ctrl.sv */
// non-secure access mode, keyed protection permission and operation timing
// assumes a same-clock register master; one read or write strobe per cycle
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "fnwc_defines.svh"
// Summary of operation
// [R1] access mode register is one-hot, at most one bit set, resets to zero
// [R2] mode value 0 read only, 1 write enabled, 2 erase enabled
// [R3] software keeps write or erase mode only while actually using it
// [R4] write or erase mode holds instruction cache invalidated throughout
// [R5] keyed write-only register: bit 0 set accepted only with valid key
// [R6] software writes a flash word at most twice between erasures
// [R7] word write finishes within 43 us, then next write accepted
// [R8] page erase finishes within 87 ms
// [R9] full array erase finishes within 173 ms
// [R10] partial erase adds 1.08 ms setup to its programmed duration
// [R11] full erase only acts when erase mode is selected
// [R12] not ready while an operation runs; no new operation starts then
module fnwc_ctrl #(
    parameter int T_WRITE_CYC = ((`FNWC_T_WRITE_US * `FNWC_CLK_KHZ) / 1000),
    parameter int T_ERASE_PAGE_CYC = (`FNWC_T_ERASE_PAGE_MS * `FNWC_CLK_KHZ),
    parameter int T_ERASE_ALL_CYC = (`FNWC_T_ERASE_ALL_MS * `FNWC_CLK_KHZ),
    parameter int T_PART_SETUP_CYC = ((`FNWC_T_PART_SETUP_US * `FNWC_CLK_KHZ) / 1000),
    parameter int MS_CYC = `FNWC_CLK_KHZ
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // register port
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // status to the system
    output logic ICACHE_INVALIDATE,
    output logic DEBUG_PROTECT_PERMIT,
    output logic READY,
    output logic OP_DONE
);
    localparam int CNT_W = `FNWC_CNT_W;
    localparam int PART_MS_MAX = (1 << (`FNWC_PART_MS_MSB - `FNWC_PART_MS_LSB + 1)) - 1;
    localparam int PART_MAX_CYC = T_PART_SETUP_CYC + PART_MS_MAX * MS_CYC;

    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    // every operation stays busy for a few cycles so status readers can see it
    if (T_WRITE_CYC < `FNWC_MIN_OP_CYC || T_ERASE_PAGE_CYC < `FNWC_MIN_OP_CYC ||
        T_ERASE_ALL_CYC < `FNWC_MIN_OP_CYC || T_PART_SETUP_CYC < `FNWC_MIN_OP_CYC) begin : g_short_op
        $error("fnwc_ctrl: operation counts below the minimum busy span");
    end

    if (MS_CYC < 1) begin : g_no_ms
        $error("fnwc_ctrl: millisecond count must be positive");
    end

    // one shared counter, so the longest operation sets its width
    if (T_WRITE_CYC >= (1 << CNT_W) || T_ERASE_PAGE_CYC >= (1 << CNT_W) ||
        T_ERASE_ALL_CYC >= (1 << CNT_W) || PART_MAX_CYC >= (1 << CNT_W)) begin : g_wide_op
        $error("fnwc_ctrl: timing counts do not fit the timer");
    end

    // ----------------------------------------
    // state and strobes
    // ----------------------------------------
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic perm_q;
    logic perm_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic inval_q;
    logic inval_d;
    logic ready_q;
    logic ready_d;
    logic done_q;
    logic done_d;
    fnwc_pkg::fnwc_op_state_t st_q;
    fnwc_pkg::fnwc_op_state_t st_d;
    logic wr_mode;
    logic wr_perm;
    logic wr_op;
    logic rd_mode;
    logic rd_status;
    logic key_ok;
    logic load;
    logic [CNT_W-1:0] load_cyc;
    logic tmr_done;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [CNT_W-1:0] to_cnt(input int c);
        return c[CNT_W-1:0];
    endfunction

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] target);
        return a == target;
    endfunction

    function automatic logic [1:0] one_hot_mode(input logic [1:0] v, input logic [1:0] old);
        // two bits set is refused so the field never leaves one-hot
        if (v == `FNWC_MODE_READ || v == `FNWC_MODE_WRITE || v == `FNWC_MODE_ERASE) begin
            return v;
        end
        return old;
    endfunction

    function automatic logic mode_opens(input logic [1:0] v);
        if (v == `FNWC_MODE_WRITE || v == `FNWC_MODE_ERASE) begin
            return 1'b1;
        end
        return 1'b0;
    endfunction

    // a command only starts when the access mode matches its kind
    function automatic logic op_start(input logic [31:0] cmd, input logic [1:0] mode);
        if (mode == `FNWC_MODE_WRITE && cmd[`FNWC_OPC_WRITE]) begin
            return 1'b1;
        end
        if (mode == `FNWC_MODE_ERASE) begin
            return cmd[`FNWC_OPC_ERASE_PAGE] || cmd[`FNWC_OPC_ERASE_ALL] || cmd[`FNWC_OPC_ERASE_PART];
        end
        return 1'b0;
    endfunction

    function automatic logic [CNT_W-1:0] op_cycles(input logic [31:0] cmd, input logic [1:0] mode);
        logic [CNT_W-1:0] c;
        c = '0;
        if (cmd[`FNWC_OPC_WRITE] && mode == `FNWC_MODE_WRITE) begin
            c = to_cnt(T_WRITE_CYC); // [R7]
        end else if (cmd[`FNWC_OPC_ERASE_PAGE] && mode == `FNWC_MODE_ERASE) begin
            c = to_cnt(T_ERASE_PAGE_CYC); // [R8]
        end else if (cmd[`FNWC_OPC_ERASE_ALL] && mode == `FNWC_MODE_ERASE) begin
            c = to_cnt(T_ERASE_ALL_CYC); // [R9]
        end else if (cmd[`FNWC_OPC_ERASE_PART] && mode == `FNWC_MODE_ERASE) begin
            // setup overhead added to the programmed milliseconds
            c = to_cnt(T_PART_SETUP_CYC + int'(cmd[`FNWC_PART_MS_MSB:`FNWC_PART_MS_LSB]) * MS_CYC); // [R10]
        end
        return c;
    endfunction

    // ----------------------------------------
    // strobe decode
    // ----------------------------------------
    always_comb begin
        wr_mode = WR && addr_hit(ADDR, `FNWC_ADDR_ACCESS_MODE);
        wr_perm = WR && addr_hit(ADDR, `FNWC_ADDR_PROTECT_PERM);
        wr_op = WR && addr_hit(ADDR, `FNWC_ADDR_OP_CTRL);
        rd_mode = RD && addr_hit(ADDR, `FNWC_ADDR_ACCESS_MODE);
        rd_status = RD && addr_hit(ADDR, `FNWC_ADDR_OP_STATUS);
        key_ok = (WDATA[`FNWC_KEY_MSB:`FNWC_KEY_LSB] == `FNWC_KEY_VALID);
    end

    // ----------------------------------------
    // access mode
    // ----------------------------------------
    always_comb begin
        mode_d = mode_q;
        // no mode change under a running operation
        if (wr_mode && st_q == fnwc_pkg::FNWC_OP_IDLE) begin
            mode_d = one_hot_mode(WDATA[`FNWC_MODE_MSB:0], mode_q); // [R1] [R2]
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mode_q <= `FNWC_ACCESS_RESET; // [R1]
        end else begin
            mode_q <= mode_d;
        end
    end

    // ----------------------------------------
    // protection permission
    // ----------------------------------------
    always_comb begin
        perm_d = perm_q;
        // sticky until reset: software has no path to clear it
        if (wr_perm && key_ok && WDATA[`FNWC_PERM_SET_BIT]) begin
            perm_d = 1'b1; // [R5]
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            perm_q <= 1'b0;
        end else begin
            perm_q <= perm_d;
        end
    end

    // ----------------------------------------
    // operation sequencer
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        load = 1'b0;
        load_cyc = '0;
        unique case (st_q)
            fnwc_pkg::FNWC_OP_IDLE: begin
                if (wr_op && op_start(WDATA, mode_q)) begin // [R11]
                    load = 1'b1;
                    load_cyc = op_cycles(WDATA, mode_q);
                    st_d = fnwc_pkg::FNWC_OP_BUSY;
                end
            end
            fnwc_pkg::FNWC_OP_BUSY: begin
                // further starts are ignored until the timer ends
                if (tmr_done) begin
                    st_d = fnwc_pkg::FNWC_OP_IDLE; // [R12]
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st_q <= fnwc_pkg::FNWC_OP_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_comb begin
        rdata_d = `FNWC_ZERO_WORD;
        // unmapped and write-only addresses read as zero
        if (rd_mode) begin
            rdata_d = {30'h00000000, mode_q};
        end else if (rd_status) begin
            rdata_d = {31'h00000000, st_q == fnwc_pkg::FNWC_OP_IDLE};
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= `FNWC_ZERO_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // status outputs
    // ----------------------------------------
    always_comb begin
        inval_d = mode_opens(mode_d); // [R4]
        ready_d = (st_d == fnwc_pkg::FNWC_OP_IDLE); // [R12]
        done_d = (st_q == fnwc_pkg::FNWC_OP_BUSY) && tmr_done;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            inval_q <= 1'b0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            inval_q <= inval_d;
            ready_q <= ready_d;
            done_q <= done_d;
        end
    end

    // ----------------------------------------
    // operation timer
    // ----------------------------------------
    fnwc_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk(REF_CLK),
        .rst(RST),
        .load(load),
        .cycles(load_cyc),
        .done(tmr_done)
    );

    assign RDATA = rdata_q;
    assign ICACHE_INVALIDATE = inval_q;
    assign DEBUG_PROTECT_PERMIT = perm_q;
    assign READY = ready_q;
    assign OP_DONE = done_q;
endmodule

/* File: fnwc_ctrl_properties.sv */
// port-level properties of the flash write control block
// assumes bind onto fnwc_ctrl; single clock, async high reset
`timescale 1ns/1ps
`include "fnwc_defines.svh"
module fnwc_ctrl_chk #(
    parameter int T_WRITE_CYC = 10, T_ERASE_PAGE_CYC = 20, T_ERASE_ALL_CYC = 30,
    parameter int T_PART_SETUP_CYC = 5, MS_CYC = 4
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic ICACHE_INVALIDATE,
    input wire logic DEBUG_PROTECT_PERMIT,
    input wire logic READY,
    input wire logic OP_DONE
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire mw = WR && ADDR == `FNWC_ADDR_ACCESS_MODE;
    wire pw = WR && ADDR == `FNWC_ADDR_PROTECT_PERM;
    mode_cache_a: assert property (mw && READY && WDATA inside {1, 2} |=> ICACHE_INVALIDATE)
        else $error("cache not invalidated");
    bad_mode_a: assert property (mw && WDATA[1:0] == 2'h3 |=> $stable(ICACHE_INVALIDATE))
        else $error("illegal mode accepted");
    busy_mode_a: assert property (mw && !READY |=> $stable(ICACHE_INVALIDATE))
        else $error("mode changed while busy");
    one_hot_a: assert property (RD && ADDR == `FNWC_ADDR_ACCESS_MODE |=> RDATA[31:2] == 0
        && RDATA[1:0] != 2'h3 && (RDATA != 0) == ICACHE_INVALIDATE) else $error("mode not one-hot");
    permit_cause_a: assert property ($rose(DEBUG_PROTECT_PERMIT) |->
        $past(pw && WDATA[31:4] == `FNWC_KEY_VALID && WDATA[0])) else $error("permit without key");
    permit_stick_a: assert property (DEBUG_PROTECT_PERMIT |=> DEBUG_PROTECT_PERMIT)
        else $error("permit dropped");
    done_pulse_a: assert property (OP_DONE |=> !OP_DONE) else $error("done too long");
    ready_done_a: assert property ($rose(READY) |-> OP_DONE) else $error("ready without done");
    busy_hold_a: assert property ($fell(READY) |-> !READY[*4]) else $error("busy too short");
    cover property ($rose(DEBUG_PROTECT_PERMIT));
    cover property ($rose(ICACHE_INVALIDATE));
    cover property (OP_DONE);
endmodule
bind fnwc_ctrl fnwc_ctrl_chk #(.T_WRITE_CYC(T_WRITE_CYC), .T_ERASE_PAGE_CYC(T_ERASE_PAGE_CYC),
    .T_ERASE_ALL_CYC(T_ERASE_ALL_CYC), .T_PART_SETUP_CYC(T_PART_SETUP_CYC), .MS_CYC(MS_CYC)) u_chk (
    .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .ICACHE_INVALIDATE(ICACHE_INVALIDATE), .DEBUG_PROTECT_PERMIT(DEBUG_PROTECT_PERMIT),
    .READY(READY), .OP_DONE(OP_DONE));

/* File: tb.sv */
// self-checking bench for the flash write control block
// assumes short timing parameters so every operation ends quickly
`timescale 1ns/1ps
`include "fnwc_defines.svh"
module tb;
    logic REF_CLK = 0, RST = 1, WR = 0, RD = 0, ICACHE_INVALIDATE, DEBUG_PROTECT_PERMIT, READY, OP_DONE;
    logic [11:0] ADDR = 0;
    logic [31:0] WDATA = 0, RDATA, rv;
    int failures = 0, check_count = 0, n;
    localparam logic [11:0] AM = `FNWC_ADDR_ACCESS_MODE, PP = `FNWC_ADDR_PROTECT_PERM, OC = `FNWC_ADDR_OP_CTRL;
    localparam logic [11:0] ST = `FNWC_ADDR_OP_STATUS;
    always #12.5 REF_CLK = ~REF_CLK;
    fnwc_ctrl #(.T_WRITE_CYC(10), .T_ERASE_PAGE_CYC(20), .T_ERASE_ALL_CYC(30), .T_PART_SETUP_CYC(5), .MS_CYC(4)) uut (
        .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .ICACHE_INVALIDATE(ICACHE_INVALIDATE), .DEBUG_PROTECT_PERMIT(DEBUG_PROTECT_PERMIT),
        .READY(READY), .OP_DONE(OP_DONE));
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_rng(string nm, int lo, int hi, int g);
        check_count++;
        if (g < lo || g > hi) begin
            failures++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task wr(logic [11:0] a, logic [31:0] d);
        @(posedge REF_CLK) ADDR <= a;
        WDATA <= d;
        WR <= 1;
        @(posedge REF_CLK) WR <= 0;
        #1;
    endtask
    task rd(logic [11:0] a);
        @(posedge REF_CLK) ADDR <= a;
        RD <= 1;
        @(posedge REF_CLK) RD <= 0;
        #1 rv = RDATA;
    endtask
    // bounded wait; n ends as the cycles waited until READY
    task wait_rdy;
        n = 0;
        while (READY !== 1'b1 && n < 2000) begin
            @(posedge REF_CLK);
            #1 n++;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rd(AM);
        chk("mode", 0, rv);
        chk("icache", 0, ICACHE_INVALIDATE);
        chk("permit", 0, DEBUG_PROTECT_PERMIT);
        chk("ready", 1, READY);
        $display("reset test done");
    endtask
    task t_modes;
        for (int m = 0; m < 3; m++) begin
            wr(AM, m);
            chk("icache", m != 0, ICACHE_INVALIDATE);
            rd(AM);
            chk("mode", m, rv);
        end
        wr(AM, 3);
        rd(AM);
        chk("mode", 2, rv);
        $display("mode test done");
    endtask
    task t_perm;
        wr(PP, 32'h12345671);
        chk("permit", 0, DEBUG_PROTECT_PERMIT);
        wr(PP, {`FNWC_KEY_VALID, 4'h0});
        chk("permit", 0, DEBUG_PROTECT_PERMIT);
        wr(PP, {`FNWC_KEY_VALID, 4'h1});
        chk("permit", 1, DEBUG_PROTECT_PERMIT);
        rd(PP);
        chk("perm read", 0, rv);
        rd(12'h7fc);
        chk("unmapped", 0, rv);
        $display("permission test done");
    endtask
    task op(logic [1:0] m, logic [31:0] c, int t);
        wr(AM, m);
        wr(OC, c);
        chk("busy", 0, READY);
        wait_rdy;
        chk_rng("op cycles", t, t + 2, n);
        chk("done", 1, OP_DONE);
        $display("op %h done", c);
    endtask
    task t_guard;
        wr(AM, 1);
        wr(OC, 4);
        chk("ready", 1, READY);
        wr(OC, 1);
        wr(AM, 0);
        wr(OC, 1);
        chk("icache", 1, ICACHE_INVALIDATE);
        rd(ST);
        chk("status busy", 0, rv);
        wait_rdy;
        chk_rng("busy tail", 3, 7, n);
        rd(ST);
        chk("status idle", 1, rv);
        wr(AM, 0);
        chk("icache", 0, ICACHE_INVALIDATE);
        $display("guard test done");
    endtask
    task t_rerst;
        wr(AM, 2);
        @(posedge REF_CLK) RST <= 1;
        repeat (2) @(posedge REF_CLK);
        RST <= 0;
        rd(AM);
        chk("mode", 0, rv);
        chk("icache", 0, ICACHE_INVALIDATE);
        chk("permit", 0, DEBUG_PROTECT_PERMIT);
        chk("ready", 1, READY);
        $display("second reset test done");
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge REF_CLK);
        RST <= 0;
        t_reset;
        t_modes;
        t_perm;
        op(1, 1, 10);
        op(2, 2, 20);
        op(2, 4, 30);
        op(2, 32'h308, 17);
        t_guard;
        t_rerst;
        print_verdict;
    end
    initial begin
        repeat (5000) @(posedge REF_CLK);
        failures++;
        print_verdict;
    end
endmodule
